// *** alu_ops_pkg.sv ***
`default_nettype none
package alu_ops_pkg;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] ACC_RESET      = 8'h00;
    localparam logic       FLAG_RESET     = 1'b0;
    // ------------------------------------------------------------
    // opcode fields: upper nibble is the group, lower the operand form
    // ------------------------------------------------------------
    localparam logic [3:0] GRP_ADD        = 4'h2;
    localparam logic [3:0] GRP_ADD_CARRY  = 4'h3;
    localparam logic [3:0] GRP_OR         = 4'h4;
    localparam logic [3:0] GRP_AND        = 4'h5;
    localparam logic [3:0] GRP_XOR        = 4'h6;
    localparam logic [3:0] GRP_SUB_BORROW = 4'h9;
    localparam logic [3:0] FORM_DIR_ACC   = 4'h2;
    localparam logic [3:0] FORM_DIR_IMM   = 4'h3;
    localparam logic [3:0] FORM_IMM       = 4'h4;
    localparam logic [3:0] FORM_DIR       = 4'h5;
    localparam logic [3:0] FORM_ONE_BYTE  = 4'h6;
    // ------------------------------------------------------------
    // single-opcode accumulator instructions
    // ------------------------------------------------------------
    localparam logic [7:0] OP_ROT_R       = 8'h03;
    localparam logic [7:0] OP_ROT_RC      = 8'h13;
    localparam logic [7:0] OP_ROT_L       = 8'h23;
    localparam logic [7:0] OP_ROT_LC      = 8'h33;
    localparam logic [7:0] OP_SWAP        = 8'hC4;
    localparam logic [7:0] OP_CLEAR       = 8'hE4;
    localparam logic [7:0] OP_INVERT      = 8'hF4;
    // ------------------------------------------------------------
    // instruction lengths in bytes
    // ------------------------------------------------------------
    localparam logic [1:0] LEN_ONE        = 2'h1;
    localparam logic [1:0] LEN_TWO        = 2'h2;
    localparam logic [1:0] LEN_THREE      = 2'h3;
    localparam logic [1:0] LEN_NONE       = 2'h0;

    typedef enum logic [3:0] {
        add_op,
        sum_with_carry_op,
        subtract_borrow_op,
        bitwise_and_op,
        bitwise_or_op,
        bitwise_xor_op,
        rotate_left_plain,
        rotate_right_plain,
        rotate_left_via_carry,
        rotate_right_via_carry,
        swap_nibbles_op,
        clear_accumulator_op,
        invert_accumulator
    } alu_fn_t;

    typedef enum logic {
        idle_st,
        second_st
    } exec_state_t;
endpackage : alu_ops_pkg
`default_nettype wire

// *** alu_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface alu_if;
    import alu_ops_pkg::*;
    alu_fn_t    fn;
    logic [7:0] a;
    logic [7:0] b;
    logic       cy_in;
    logic [7:0] result;
    logic       cy_out;
    logic       ac_out;
    logic       ov_out;
    modport core (input fn, input a, input b, input cy_in,
                  output result, output cy_out, output ac_out, output ov_out);
    modport ctrl (output fn, output a, output b, output cy_in,
                  input result, input cy_out, input ac_out, input ov_out);
endinterface : alu_if
`default_nettype wire

// *** alu_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module alu_core (
    alu_if.core bus
);
    import alu_ops_pkg::*;
    logic [8:0] wide;
    logic [4:0] low;
    always_comb begin
        wide = 9'h000;
        low = 5'h00;
        bus.result = bus.a;
        bus.cy_out = bus.cy_in;
        bus.ac_out = 1'b0;
        bus.ov_out = 1'b0;
        unique case (bus.fn)
            add_op, sum_with_carry_op: begin
                // plain add ignores carry; carry form folds it in
                wide = {1'b0, bus.a} + {1'b0, bus.b}
                     + {8'h00, (bus.fn == sum_with_carry_op) & bus.cy_in};
                low = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]}
                    + {4'h0, (bus.fn == sum_with_carry_op) & bus.cy_in};
                bus.result = wide[7:0];
                bus.cy_out = wide[8];
                bus.ac_out = low[4];
                bus.ov_out = (bus.a[7] == bus.b[7]) && (wide[7] != bus.a[7]);
            end
            subtract_borrow_op: begin
                wide = {1'b0, bus.a} - {1'b0, bus.b} - {8'h00, bus.cy_in};
                low = {1'b0, bus.a[3:0]} - {1'b0, bus.b[3:0]} - {4'h0, bus.cy_in};
                bus.result = wide[7:0];
                bus.cy_out = wide[8];
                bus.ac_out = low[4];
                bus.ov_out = (bus.a[7] != bus.b[7]) && (wide[7] != bus.a[7]);
            end
            bitwise_and_op: bus.result = bus.a & bus.b;
            bitwise_or_op: bus.result = bus.a | bus.b;
            bitwise_xor_op: bus.result = bus.a ^ bus.b;
            rotate_left_plain: bus.result = {bus.a[6:0], bus.a[7]};
            rotate_right_plain: bus.result = {bus.a[0], bus.a[7:1]};
            rotate_left_via_carry: begin
                bus.result = {bus.a[6:0], bus.cy_in};
                bus.cy_out = bus.a[7];
            end
            rotate_right_via_carry: begin
                bus.result = {bus.cy_in, bus.a[7:1]};
                bus.cy_out = bus.a[0];
            end
            swap_nibbles_op: bus.result = {bus.a[3:0], bus.a[7:4]};
            clear_accumulator_op: bus.result = 8'h00;
            invert_accumulator: bus.result = ~bus.a;
        endcase
    end
endmodule : alu_core
`default_nettype wire

// *** accumulator_alu_ops.sv ***
// Behaviour
// - add register or indirect byte to accumulator: one byte, one cycle
// - add direct or immediate byte to accumulator: two bytes, one cycle
// - add with carry adds operand plus carry flag; 1 or 2 bytes, one cycle
// - subtract operand and borrow from accumulator; 1 or 2 bytes, one cycle
// - and into accumulator from register, direct, indirect or immediate, one cycle
// - and accumulator into direct byte: two bytes, one cycle
// - and immediate into direct byte: three bytes, two cycles, accumulator untouched
// - or group mirrors the and group in forms, lengths and cycles
// - xor group mirrors the and group in forms, lengths and cycles
// - clear, invert and plain rotates act on accumulator, one byte, one cycle
// - left rotate through carry is a nine-bit loop, one byte, one cycle
// - right rotate through carry: bit zero to carry, carry to top bit
// - nibble swap exchanges accumulator halves, one byte, one cycle
`timescale 1ns/1ps
`default_nettype none
module accumulator_alu_ops (
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    input  wire logic       start_i,
    input  wire logic [7:0] opcode_i,
    input  wire logic [7:0] operand_i,
    input  wire logic [7:0] imm_i,
    output logic            ready_o,
    output logic            done_o,
    output logic            illegal_o,
    output logic [1:0]      length_o,
    output logic [7:0]      acc_o,
    output logic            carry_o,
    output logic            aux_carry_o,
    output logic            overflow_o,
    output logic            direct_wr_o,
    output logic [7:0]      direct_wdata_o
);
    import alu_ops_pkg::*;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    alu_fn_t    dec_fn;
    logic       dec_legal;
    logic       dec_to_direct;
    logic       dec_two_cycle;
    logic [1:0] dec_len;
    logic [3:0] grp;
    logic [3:0] form;

    assign grp  = opcode_i[7:4];
    assign form = opcode_i[3:0];

    always_comb begin
        dec_fn = add_op;
        dec_legal = 1'b1;
        dec_to_direct = 1'b0;
        dec_two_cycle = 1'b0;
        dec_len = LEN_ONE;
        unique case (opcode_i)
            OP_ROT_R: dec_fn = rotate_right_plain;
            OP_ROT_RC: dec_fn = rotate_right_via_carry;
            OP_ROT_L: dec_fn = rotate_left_plain;
            OP_ROT_LC: dec_fn = rotate_left_via_carry;
            OP_SWAP: dec_fn = swap_nibbles_op;
            OP_CLEAR: dec_fn = clear_accumulator_op;
            OP_INVERT: dec_fn = invert_accumulator;
            default: begin
                unique case (grp)
                    GRP_ADD: dec_fn = add_op;
                    GRP_ADD_CARRY: dec_fn = sum_with_carry_op;
                    GRP_SUB_BORROW: dec_fn = subtract_borrow_op;
                    GRP_AND: dec_fn = bitwise_and_op;
                    GRP_OR: dec_fn = bitwise_or_op;
                    GRP_XOR: dec_fn = bitwise_xor_op;
                    default: dec_legal = 1'b0;
                endcase
                // register and indirect forms are single byte
                if (form >= FORM_ONE_BYTE) begin
                    dec_len = LEN_ONE;
                end else if (form == FORM_IMM || form == FORM_DIR) begin
                    dec_len = LEN_TWO;
                end else if (form == FORM_DIR_ACC || form == FORM_DIR_IMM) begin
                    // direct destination exists only for the logic groups
                    if (grp != GRP_AND && grp != GRP_OR && grp != GRP_XOR) begin
                        dec_legal = 1'b0;
                    end
                    dec_to_direct = 1'b1;
                    dec_two_cycle = (form == FORM_DIR_IMM);
                    dec_len = (form == FORM_DIR_IMM) ? LEN_THREE : LEN_TWO;
                end else begin
                    dec_legal = 1'b0;
                end
            end
        endcase
        if (!dec_legal) begin
            dec_len = LEN_NONE;
        end
    end

    // ------------------------------------------------------------
    // datapath
    // ------------------------------------------------------------
    alu_if alu ();
    alu_core u_alu (
        .bus (alu.core)
    );

    exec_state_t state;
    exec_state_t next_state;
    alu_fn_t     hold_fn;
    alu_fn_t     next_hold_fn;
    logic [7:0]  hold_a;
    logic [7:0]  next_hold_a;
    logic [7:0]  hold_b;
    logic [7:0]  next_hold_b;
    logic [7:0]  acc;
    logic [7:0]  next_acc;
    logic        cy;
    logic        next_cy;
    logic        ac;
    logic        next_ac;
    logic        ov;
    logic        next_ov;
    logic        done;
    logic        next_done;
    logic        illegal;
    logic        next_illegal;
    logic [1:0]  len;
    logic [1:0]  next_len;
    logic        dwr;
    logic        next_dwr;
    logic [7:0]  dwdata;
    logic [7:0]  next_dwdata;
    logic        take;
    logic        arith;

    assign take = start_i && (state == idle_st);

    // second cycle of the three-byte form works from latched bytes, so the
    // fetch logic is free to move on once the request is taken
    assign alu.fn    = (state == second_st) ? hold_fn : dec_fn;
    assign alu.a     = (state == second_st) ? hold_a : acc;
    assign alu.b     = (state == second_st) ? hold_b : operand_i;
    assign alu.cy_in = cy;
    assign arith     = (alu.fn == add_op) || (alu.fn == sum_with_carry_op)
                    || (alu.fn == subtract_borrow_op);

    always_comb begin
        next_state = state;
        next_hold_fn = hold_fn;
        next_hold_a = hold_a;
        next_hold_b = hold_b;
        next_acc = acc;
        next_cy = cy;
        next_ac = ac;
        next_ov = ov;
        next_done = 1'b0;
        next_illegal = 1'b0;
        next_len = len;
        next_dwr = 1'b0;
        next_dwdata = dwdata;
        unique case (state)
            idle_st: begin
                if (take) begin
                    next_len = dec_len;
                    if (!dec_legal) begin
                        next_illegal = 1'b1;
                        next_done = 1'b1;
                    end else if (dec_two_cycle) begin
                        next_state = second_st;
                        next_hold_fn = dec_fn;
                        next_hold_a = operand_i;
                        next_hold_b = imm_i;
                    end else begin
                        next_done = 1'b1;
                        if (dec_to_direct) begin
                            next_dwr = 1'b1;
                            next_dwdata = alu.result;
                        end else begin
                            next_acc = alu.result;
                        end
                        if (arith) begin
                            next_ac = alu.ac_out;
                            next_ov = alu.ov_out;
                        end
                        next_cy = alu.cy_out;
                    end
                end
            end
            second_st: begin
                // accumulator is not written here
                next_dwr = 1'b1;
                next_dwdata = alu.result;
                next_done = 1'b1;
                next_state = idle_st;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state <= idle_st;
            hold_fn <= add_op;
            hold_a <= ACC_RESET;
            hold_b <= ACC_RESET;
            acc <= ACC_RESET;
            cy <= FLAG_RESET;
            ac <= FLAG_RESET;
            ov <= FLAG_RESET;
            done <= 1'b0;
            illegal <= 1'b0;
            len <= LEN_NONE;
            dwr <= 1'b0;
            dwdata <= ACC_RESET;
        end else begin
            state <= next_state;
            hold_fn <= next_hold_fn;
            hold_a <= next_hold_a;
            hold_b <= next_hold_b;
            acc <= next_acc;
            cy <= next_cy;
            ac <= next_ac;
            ov <= next_ov;
            done <= next_done;
            illegal <= next_illegal;
            len <= next_len;
            dwr <= next_dwr;
            dwdata <= next_dwdata;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign ready_o        = (state == idle_st);
    assign done_o         = done;
    assign illegal_o      = illegal;
    assign length_o       = len;
    assign acc_o          = acc;
    assign carry_o        = cy;
    assign aux_carry_o    = ac;
    assign overflow_o     = ov;
    assign direct_wr_o    = dwr;
    assign direct_wdata_o = dwdata;
endmodule : accumulator_alu_ops
`default_nettype wire

// *** seq_tracker.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// sequencer side: program counter steps by the reported length
// ------------------------------------------------------------
module seq_tracker (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        done_i,
    input  wire logic [1:0]  length_i,
    output logic      [15:0] pc_o
);
    // advance only on completion, so operand bytes are skipped before the next fetch
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pc_o <= 16'h0000;
        end else if (done_i) begin
            pc_o <= pc_o + 16'(length_i);
        end
    end
endmodule : seq_tracker
`default_nettype wire

// *** accumulator_alu_ops_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module accumulator_alu_ops_props
    import alu_ops_pkg::*;
(
    input wire logic       mclk_i,
    input wire logic       rst_i,
    input wire logic       start_i,
    input wire logic [7:0] opcode_i,
    input wire logic [7:0] operand_i,
    input wire logic [7:0] imm_i,
    input wire logic       ready_o,
    input wire logic       done_o,
    input wire logic       illegal_o,
    input wire logic [1:0] length_o,
    input wire logic [7:0] acc_o,
    input wire logic       carry_o,
    input wire logic       aux_carry_o,
    input wire logic       overflow_o,
    input wire logic       direct_wr_o,
    input wire logic [7:0] direct_wdata_o
);
    // ------------------------------------------------------------
    // history of inputs and state, one and two edges back
    // ------------------------------------------------------------
    logic [7:0] pa, pa2, pd, pq, pm, pm2;
    logic [2:0] pf;
    logic       take, lg, dimm;
    assign take = start_i && ready_o;
    assign lg   = take && opcode_i[7:4] inside {GRP_OR, GRP_AND, GRP_XOR} && opcode_i[3:0] >= FORM_DIR_ACC;
    assign dimm = lg && opcode_i[3:0] == FORM_DIR_IMM;
    always_ff @(posedge mclk_i) begin
        pa  <= acc_o;
        pa2 <= pa;
        pd  <= operand_i;
        pq  <= acc_o & operand_i;
        pm  <= operand_i & imm_i;
        pm2 <= pm;
        pf  <= {carry_o, aux_carry_o, overflow_o};
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    property p_one_cycle; take && !dimm |=> done_o; endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("op did not finish in one cycle");
    property p_two_cycle; dimm |=> !ready_o && !done_o && length_o == LEN_THREE ##1 done_o && direct_wr_o; endproperty
    a_two_cycle: assert property (p_two_cycle) else $error("direct immediate form timing wrong");
    property p_dimm_and; take && opcode_i == {GRP_AND, FORM_DIR_IMM} |=> ##1 direct_wdata_o == pm2 && acc_o == pa2;
    endproperty
    a_dimm_and: assert property (p_dimm_and) else $error("direct immediate and result wrong");
    property p_dir_acc; take && opcode_i == {GRP_AND, FORM_DIR_ACC} |=> direct_wr_o && direct_wdata_o == pq
        && length_o == LEN_TWO && acc_o == pa; endproperty
    a_dir_acc: assert property (p_dir_acc) else $error("direct accumulator and wrong");
    property p_add; take && opcode_i[7:4] == GRP_ADD && opcode_i[3:0] >= FORM_IMM |=> acc_o == 8'(pa + pd); endproperty
    a_add: assert property (p_add) else $error("sum wrong");
    property p_swap; take && opcode_i == OP_SWAP |=> acc_o == {pa[3:0], pa[7:4]}; endproperty
    a_swap: assert property (p_swap) else $error("nibble swap wrong");
    property p_rlc; take && opcode_i == OP_ROT_LC |=> acc_o == {pa[6:0], pf[2]} && carry_o == pa[7]; endproperty
    a_rlc: assert property (p_rlc) else $error("left carry rotate wrong");
    property p_rrc; take && opcode_i == OP_ROT_RC |=> acc_o == {pf[2], pa[7:1]} && carry_o == pa[0]; endproperty
    a_rrc: assert property (p_rrc) else $error("right carry rotate wrong");
    property p_logic_flags; lg |=> {carry_o, aux_carry_o, overflow_o} == pf; endproperty
    a_logic_flags: assert property (p_logic_flags) else $error("logic op changed flags");
endmodule : accumulator_alu_ops_props
bind accumulator_alu_ops accumulator_alu_ops_props u_props (
    .mclk_i(mclk_i), .rst_i(rst_i), .start_i(start_i), .opcode_i(opcode_i), .operand_i(operand_i),
    .imm_i(imm_i), .ready_o(ready_o), .done_o(done_o), .illegal_o(illegal_o), .length_o(length_o),
    .acc_o(acc_o), .carry_o(carry_o), .aux_carry_o(aux_carry_o), .overflow_o(overflow_o),
    .direct_wr_o(direct_wr_o), .direct_wdata_o(direct_wdata_o));
`default_nettype wire

// *** accumulator_alu_ops_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module accumulator_alu_ops_test;
    import alu_ops_pkg::*;
    // ------------------------------------------------------------
    // stimulus, outputs and expected state
    // ------------------------------------------------------------
    logic        mclk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        start_i = 1'b0;
    logic [7:0]  opcode_i = 8'h00;
    logic [7:0]  operand_i = 8'h00;
    logic [7:0]  imm_i = 8'h00;
    logic        ready_o, done_o, illegal_o, carry_o, aux_carry_o, overflow_o, direct_wr_o;
    logic [1:0]  length_o, e_len;
    logic [7:0]  acc_o, direct_wdata_o, e_dw;
    logic [7:0]  m_acc = 8'h00;
    logic        m_c = 1'b0, m_ac = 1'b0, m_ov = 1'b0, e_ill, e_dwr;
    logic [15:0] pc, pc_exp = 16'h0000;
    int          error_cnt = 0, cmp_count = 0, cycles = 0, e_cyc;

    initial forever #5 mclk_i = ~mclk_i;
    accumulator_alu_ops dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .start_i(start_i), .opcode_i(opcode_i), .operand_i(operand_i),
        .imm_i(imm_i), .ready_o(ready_o), .done_o(done_o), .illegal_o(illegal_o), .length_o(length_o),
        .acc_o(acc_o), .carry_o(carry_o), .aux_carry_o(aux_carry_o), .overflow_o(overflow_o),
        .direct_wr_o(direct_wr_o), .direct_wdata_o(direct_wdata_o));
    seq_tracker u_seq (.mclk_i(mclk_i), .rst_i(rst_i), .done_i(done_o), .length_i(length_o), .pc_o(pc));

    task automatic finish_test();
        $display("errors %0d comparisons %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test
    task automatic chk(input bit ok, input string what);
        cmp_count++;
        if (!ok) begin
            error_cnt++;
            $display("Error %0t: %s", $time, what);
        end
    endtask : chk
    // ------------------------------------------------------------
    // reference: next accumulator, flags and expected answer
    // ------------------------------------------------------------
    function automatic void model(input logic [7:0] op, a, b);
        logic [8:0] s;
        logic [7:0] x, y;
        logic       ci;
        e_len = LEN_ONE; e_cyc = 1; e_ill = 1'b0; e_dwr = 1'b0;
        case (op)
            OP_ROT_R:  m_acc = {m_acc[0], m_acc[7:1]};
            OP_ROT_RC: {m_acc, m_c} = {m_c, m_acc};
            OP_ROT_L:  m_acc = {m_acc[6:0], m_acc[7]};
            OP_ROT_LC: {m_c, m_acc} = {m_acc, m_c};
            OP_SWAP:   m_acc = {m_acc[3:0], m_acc[7:4]};
            OP_CLEAR:  m_acc = 8'h00;
            OP_INVERT: m_acc = ~m_acc;
            default: begin
                e_len = (op[3:0] < FORM_ONE_BYTE) ? LEN_TWO : LEN_ONE;
                ci = (op[7:4] == GRP_ADD) ? 1'b0 : m_c;
                x = (op[3:0] == FORM_DIR_IMM) ? a : m_acc;
                y = (op[3:0] == FORM_DIR_IMM) ? b : a;
                if (op[7:4] inside {GRP_ADD, GRP_ADD_CARRY} && op[3:0] >= FORM_IMM) begin
                    s = m_acc + a + ci;
                    m_ac = (m_acc[3:0] + a[3:0] + ci) > 5'h0F;
                    m_ov = (m_acc[7] == a[7]) && (s[7] != m_acc[7]);
                    {m_c, m_acc} = s;
                end else if (op[7:4] == GRP_SUB_BORROW && op[3:0] >= FORM_IMM) begin
                    s = {1'b0, m_acc} - {1'b0, a} - ci;
                    m_ac = {1'b0, m_acc[3:0]} < ({1'b0, a[3:0]} + ci);
                    m_ov = (m_acc[7] != a[7]) && (s[7] != m_acc[7]);
                    {m_c, m_acc} = s;
                end else if (op[7:4] inside {GRP_OR, GRP_AND, GRP_XOR} && op[3:0] >= FORM_DIR_ACC) begin
                    s[7:0] = (op[7:4] == GRP_OR) ? (x | y) : (op[7:4] == GRP_AND) ? (x & y) : (x ^ y);
                    if (op[3:0] == FORM_DIR_IMM) begin
                        e_len = LEN_THREE;
                        e_cyc = 2;
                    end
                    if (op[3:0] <= FORM_DIR_IMM) {e_dwr, e_dw} = {1'b1, s[7:0]};
                    else m_acc = s[7:0];
                end else {e_ill, e_len} = {1'b1, LEN_NONE};
            end
        endcase
        pc_exp += 16'(e_len);
    endfunction : model
    // one request, start raised for one edge, judged when done arrives
    task automatic exec(input logic [7:0] op, a, b);
        int n;
        model(op, a, b);
        @(posedge mclk_i);
        start_i <= 1'b1; opcode_i <= op; operand_i <= a; imm_i <= b;
        @(posedge mclk_i);
        start_i <= 1'b0;
        #1;
        n = 1;
        while (done_o !== 1'b1 && n < 4) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        chk(n == e_cyc && illegal_o === e_ill && length_o === e_len, "cycles, length or illegal");
        chk({acc_o, carry_o, aux_carry_o, overflow_o} === {m_acc, m_c, m_ac, m_ov}, "acc or flags");
        chk(direct_wr_o === e_dwr && (!e_dwr || direct_wdata_o === e_dw), "direct write");
    endtask : exec
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        #1;
        chk({ready_o, done_o, illegal_o, direct_wr_o, length_o, acc_o, carry_o, aux_carry_o, overflow_o,
             direct_wdata_o} === {4'h8, LEN_NONE, ACC_RESET, {3{FLAG_RESET}}, 8'h00}, "reset state");
    endtask : t_reset
    task automatic t_arith();
        logic [7:0] ops [15] = '{8'h24, 8'h28, 8'h26, 8'h25, 8'h2F, 8'h34, 8'h39, 8'h37, 8'h35,
                                 8'h94, 8'h98, 8'h96, 8'h95, 8'h9F, 8'h27};
        logic [7:0] val [15] = '{8'h7F, 8'h01, 8'hFF, 8'h0F, 8'h88, 8'hF1, 8'h80, 8'h7F, 8'h00,
                                 8'h01, 8'h7F, 8'hFF, 8'h80, 8'h0E, 8'h99};
        foreach (ops[i]) exec(ops[i], val[i], 8'h00);
    endtask : t_arith
    task automatic t_logic();
        for (int g = 4; g <= 6; g++) begin
            for (int f = 2; f <= 15; f++) exec({4'(g), 4'(f)}, 8'(8'h3C ^ (f * 17)), 8'(8'h5A + f));
        end
    endtask : t_logic
    task automatic t_accum();
        logic [7:0] ops [9] = '{OP_ROT_LC, OP_ROT_R, OP_ROT_RC, OP_ROT_L, OP_SWAP, OP_CLEAR,
                                OP_INVERT, OP_ROT_RC, OP_ROT_LC};
        exec({GRP_OR, FORM_IMM}, 8'hA5, 8'h00);
        exec({GRP_ADD, FORM_IMM}, 8'hC0, 8'h00);
        foreach (ops[i]) exec(ops[i], 8'h00, 8'h00);
    endtask : t_accum
    task automatic t_illegal();
        logic [7:0] ops [8] = '{8'h00, 8'h21, 8'h32, 8'h40, 8'h51, 8'h90, 8'h93, 8'hA4};
        foreach (ops[i]) exec(ops[i], 8'hFF, 8'hFF);
    endtask : t_illegal
    // a second request during the busy cycle must be dropped, not queued
    task automatic t_refuse();
        model({GRP_AND, FORM_DIR_IMM}, 8'hC3, 8'h5F);
        @(posedge mclk_i);
        start_i <= 1'b1; opcode_i <= {GRP_AND, FORM_DIR_IMM}; operand_i <= 8'hC3; imm_i <= 8'h5F;
        @(posedge mclk_i);
        opcode_i <= OP_CLEAR;
        #1;
        chk(ready_o === 1'b0 && done_o === 1'b0 && length_o === LEN_THREE, "busy cycle");
        @(posedge mclk_i);
        start_i <= 1'b0;
        #1;
        chk(done_o === 1'b1 && direct_wr_o === 1'b1 && direct_wdata_o === e_dw, "direct result");
        @(posedge mclk_i);
        #1;
        chk(done_o === 1'b0 && acc_o === m_acc && m_acc !== 8'h00, "refused request");
    endtask : t_refuse

    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            $display("Error %0t: timeout", $time);
            finish_test();
        end
    end
    initial begin
        repeat (12) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        t_reset();
        t_arith();
        t_logic();
        t_accum();
        t_illegal();
        t_refuse();
        chk(pc === pc_exp, "program counter");
        finish_test();
    end
endmodule : accumulator_alu_ops_test
`default_nettype wire
